// file: hw/ifre_pkg.sv
// ----------------------------------------------------------------------
// Register map, field positions and reset values
// ----------------------------------------------------------------------
package ifre_pkg;
   // Byte addresses of the APB registers, one aligned word each
   localparam logic [7:0] ADDR_PTF    = 8'h00; // Pin and transition flags
   localparam logic [7:0] ADDR_TOF    = 8'h04; // Timer overflow flags
   localparam logic [7:0] ADDR_WPF    = 8'h08; // Wake pin flags
   localparam logic [7:0] ADDR_EDGE   = 8'h0c; // Edge selects, pin modes
   localparam logic [7:0] ADDR_ENA    = 8'h10; // Request enables
   localparam logic [7:0] ADDR_ENTRY  = 8'h14; // Reset entry status

   // Flag bit positions
   localparam int DT_BIT  = 7;                // Direct transition flag
   localparam int P3_BIT  = 3;                // Pin three flag
   localparam int P0_BIT  = 0;                // Pin zero flag
   localparam int TOV_BIT = 5;                // Timer overflow flag
   localparam int WK_BIT  = 5;                // Wake pin flag

   // Enable register positions (flag positions reused, timer at bit 1)
   localparam int EN_TOV_BIT = 1;             // Timer overflow enable

   // Edge register: selects in low bits, pin modes in high bits
   localparam int ES_P0   = 0;                // Pin zero edge select
   localparam int ES_P3   = 3;                // Pin three edge select
   localparam int ES_WK   = 5;                // Wake pin edge select
   localparam int PM_P0   = 8;                // Pin zero is interrupt input
   localparam int PM_P3   = 11;               // Pin three is interrupt input
   localparam int PM_WK   = 13;               // Wake pin is interrupt input

   // Reserved bits that always read as one
   localparam logic [7:0] PTF_ONES = 8'h30;
   localparam logic [7:0] TOF_ONES = 8'h1f;
   localparam logic [7:0] WPF_ONES = 8'hc0;

   // Reset values
   localparam logic [7:0]  FLAG_RST = 8'h00;
   localparam logic [15:0] EDGE_RST = 16'h0000;
   localparam logic [7:0]  ENA_RST  = 8'h00;

   // Reset vector bytes: upper byte at the lowest address
   localparam logic [15:0] VEC_ADDR_HI = 16'h0000;
   localparam logic [15:0] VEC_ADDR_LO = 16'h0001;

   // Reset entry sequencer, one-hot
   typedef enum logic [4:0] {
      ST_HOLD  = 5'b00001,                    // First cycle after release
      ST_MASK  = 5'b00010,                    // Raise interrupt mask
      ST_FHI   = 5'b00100,                    // Upper vector byte returns
      ST_FLO   = 5'b01000,                    // Lower vector byte returns
      ST_RUN   = 5'b10000                     // Program running
   } ifre_state_e;
endpackage : ifre_pkg

// file: hw/ifre_top.sv
`timescale 1ns/1ps
// Contract
// - Sleep direct transfer with enable sets bit 7
// - Writing 0 clears direct transition flag
// - Selected pin three edge sets bit 3
// - Selected pin zero edge sets bit 0
// - Pin flags clear only by writing 0
// - Timer overflow sets bit 5, second register
// - Writing 0 clears timer overflow flag
// - Selected wake pin edge sets bit 5
// - Writing 0 clears wake pin flag
// - Fixed-one reserved bits read as one
// - Fixed-zero reserved bits read as zero
// - Reset pin low halts all processing
// - Reset initialises all state and registers
// - Release after held low starts reset entry
// - Reset entry first sets interrupt mask
// - Fetch vector from lowest two bytes, run
// - Edge select 0 falling, 1 rising
// - Flags reach CPU only when enabled
module ifre_top
(
   input  wire logic        ref_clk_in,          // 40 MHz clock
   input  wire logic        reset_n_in,          // Chip clear pin, async
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   // Request sources
   input  wire logic        sleep_direct_in,     // Sleep caused direct move
   input  wire logic        direct_transition_on_in, // From system ctrl two
   input  wire logic        timer_ovf_in,        // Timer overflow pulse
   input  wire logic        ext_pin_three_in,    // Asynchronous pin
   input  wire logic        ext_pin_zero_in,     // Asynchronous pin
   input  wire logic        wake_pin_in,         // Asynchronous pin
   // CPU side
   output logic             irq_out,             // Enabled request pending
   output logic             ccr_i_mask_out,      // Interrupt mask bit
   output logic             vec_rd_out,          // Vector byte read strobe
   output logic [15:0]      vec_addr_out,        // Vector byte address
   input  wire logic [7:0]  vec_data_in,         // Byte, in the address cycle
   output logic             pc_load_out,         // Load program counter
   output logic [15:0]      pc_value_out,        // Start address
   output logic             cpu_run_out          // Execution may proceed
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0]  sync1_r;                  // Pin sync, first stage
   logic [2:0]  sync2_r;                  // Pin sync, second stage
   logic [2:0]  sync3_r;                  // Pin sync, third stage
   logic [2:0]  level_r;                  // Accepted pin level
   logic [2:0]  stable;                   // Stages two and three agree
   logic [2:0]  change;                   // Accepted level moves
   logic [2:0]  edge_sel;                 // 1 rising, 0 falling
   logic [2:0]  pin_mode;                 // Pin is interrupt input
   logic [2:0]  pin_hit;                  // Selected edge seen
   logic        dt_hit;                   // Direct transition event
   logic [7:0]  ptf_r;                    // Pin and transition flags
   logic [7:0]  tof_r;                    // Timer overflow flags
   logic [7:0]  wpf_r;                    // Wake pin flags
   logic [15:0] edge_r;                   // Edge selects and pin modes
   logic [7:0]  ena_r;                    // Request enables
   logic        irq_r;                    // Registered request
   logic        access;                   // APB access phase
   logic        wr_go;                    // Write commits now
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic [31:0] rd_mux;                   // Read data before the flop
   logic        mapped;                   // Address decodes
   ifre_pkg::ifre_state_e st_r;           // Reset entry state
   logic        ccr_i_r;
   logic        vec_rd_r;
   logic [15:0] vec_addr_r;
   logic [7:0]  pc_hi_r;                  // Captured upper vector byte
   logic        pc_load_r;
   logic [15:0] pc_value_r;
   logic        cpu_run_r;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   // Three stages reset to the idle-high level, so release fakes no edge
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sync1_r <= 3'h7;
         sync2_r <= 3'h7;
         sync3_r <= 3'h7;
      end
      else
      begin
         sync1_r <= {wake_pin_in, ext_pin_three_in, ext_pin_zero_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Accepted level; starts high since the pins idle high
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         level_r <= 3'h7;
      else
         level_r <= level_r ^ change;
   end

   // Bit 0 pin zero, bit 1 pin three, bit 2 wake pin
   assign edge_sel = {edge_r[ifre_pkg::ES_WK], edge_r[ifre_pkg::ES_P3],
                      edge_r[ifre_pkg::ES_P0]};
   assign pin_mode = {edge_r[ifre_pkg::PM_WK], edge_r[ifre_pkg::PM_P3],
                      edge_r[ifre_pkg::PM_P0]};
   assign stable   = ~(sync2_r ^ sync3_r);
   assign change   = stable & (sync3_r ^ level_r);
   // Rising when select is 1, falling when 0
   assign pin_hit  = pin_mode & change & ~(sync3_r ^ edge_sel);
   // Only a direct transfer with the control bit on counts
   assign dt_hit   = sleep_direct_in & direct_transition_on_in;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // One wait cycle: pready rises in the second access cycle
   assign access = psel_in & penable_in;
   assign wr_go  = access & pwrite_in & pready_r;

   // Read mux with reserved bits forced
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      if (paddr_in == ifre_pkg::ADDR_PTF)
         rd_mux[7:0] = ptf_r | ifre_pkg::PTF_ONES;
      else if (paddr_in == ifre_pkg::ADDR_TOF)
         rd_mux[7:0] = tof_r | ifre_pkg::TOF_ONES;
      else if (paddr_in == ifre_pkg::ADDR_WPF)
         rd_mux[7:0] = wpf_r | ifre_pkg::WPF_ONES;
      else if (paddr_in == ifre_pkg::ADDR_EDGE)
         rd_mux[15:0] = edge_r;
      else if (paddr_in == ifre_pkg::ADDR_ENA)
         rd_mux[7:0] = ena_r;
      else if (paddr_in == ifre_pkg::ADDR_ENTRY)
         rd_mux[2:0] = {cpu_run_r, pc_load_r, ccr_i_r};
      else
         mapped = 1'b0;                              // Unmapped: error
   end

   // Answer flops; read data settles with pready
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~mapped;
         if (access & ~pready_r & ~pwrite_in)
            prdata_r <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Request flags
   // ----------------------------------------------------------------
   // Write 0 clears, write 1 keeps; a set in the same cycle wins.
   // Fixed bits are never stored, so reserved zeros read zero.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ptf_r <= ifre_pkg::FLAG_RST;
      else
      begin
         if (wr_go && paddr_in == ifre_pkg::ADDR_PTF)
         begin
            ptf_r[ifre_pkg::DT_BIT] <= (ptf_r[ifre_pkg::DT_BIT]
               & pwdata_in[ifre_pkg::DT_BIT]) | dt_hit;
            ptf_r[ifre_pkg::P3_BIT] <= (ptf_r[ifre_pkg::P3_BIT]
               & pwdata_in[ifre_pkg::P3_BIT]) | pin_hit[1];
            ptf_r[ifre_pkg::P0_BIT] <= (ptf_r[ifre_pkg::P0_BIT]
               & pwdata_in[ifre_pkg::P0_BIT]) | pin_hit[0];
         end
         else
         begin
            ptf_r[ifre_pkg::DT_BIT] <= ptf_r[ifre_pkg::DT_BIT]
               | dt_hit;
            ptf_r[ifre_pkg::P3_BIT] <= ptf_r[ifre_pkg::P3_BIT]
               | pin_hit[1];
            ptf_r[ifre_pkg::P0_BIT] <= ptf_r[ifre_pkg::P0_BIT]
               | pin_hit[0];
         end
      end
   end

   // Timer overflow flag, same-clock pulse, no sync needed
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         tof_r <= ifre_pkg::FLAG_RST;
      else if (wr_go && paddr_in == ifre_pkg::ADDR_TOF)
         tof_r[ifre_pkg::TOV_BIT] <= (tof_r[ifre_pkg::TOV_BIT]
            & pwdata_in[ifre_pkg::TOV_BIT]) | timer_ovf_in;
      else
         tof_r[ifre_pkg::TOV_BIT] <= tof_r[ifre_pkg::TOV_BIT]
            | timer_ovf_in;
   end

   // Wake pin flag
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         wpf_r <= ifre_pkg::FLAG_RST;
      else if (wr_go && paddr_in == ifre_pkg::ADDR_WPF)
         wpf_r[ifre_pkg::WK_BIT] <= (wpf_r[ifre_pkg::WK_BIT]
            & pwdata_in[ifre_pkg::WK_BIT]) | pin_hit[2];
      else
         wpf_r[ifre_pkg::WK_BIT] <= wpf_r[ifre_pkg::WK_BIT]
            | pin_hit[2];
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Switching a pin mode fakes no edge; level tracking runs in every mode
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         edge_r <= ifre_pkg::EDGE_RST;
         ena_r  <= ifre_pkg::ENA_RST;
      end
      else if (wr_go && paddr_in == ifre_pkg::ADDR_EDGE)
         edge_r <= pwdata_in[15:0];
      else if (wr_go && paddr_in == ifre_pkg::ADDR_ENA)
         ena_r  <= pwdata_in[7:0];
   end

   // Enabled flags only; clearing an enable masks its request
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         irq_r <= 1'b0;
      else
         irq_r <= (ptf_r[ifre_pkg::DT_BIT] & ena_r[ifre_pkg::DT_BIT])
                | (ptf_r[ifre_pkg::P3_BIT] & ena_r[ifre_pkg::P3_BIT])
                | (ptf_r[ifre_pkg::P0_BIT] & ena_r[ifre_pkg::P0_BIT])
                | (wpf_r[ifre_pkg::WK_BIT] & ena_r[ifre_pkg::WK_BIT])
                | (tof_r[ifre_pkg::TOV_BIT]
                   & ena_r[ifre_pkg::EN_TOV_BIT]);
   end

   // ----------------------------------------------------------------
   // Reset entry sequencer
   // ----------------------------------------------------------------
   // Async reset parks everything; release starts the vector fetch
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st_r       <= ifre_pkg::ST_HOLD;
         ccr_i_r    <= 1'b1;
         vec_rd_r   <= 1'b0;
         vec_addr_r <= ifre_pkg::VEC_ADDR_HI;
         pc_hi_r    <= 8'h00;
         pc_load_r  <= 1'b0;
         pc_value_r <= 16'h0000;
         cpu_run_r  <= 1'b0;
      end
      else
      begin
         pc_load_r <= 1'b0;
         case (st_r)
            // Release seen: start handling
            ifre_pkg::ST_HOLD:
               st_r <= ifre_pkg::ST_MASK;
            // Mask first, then ask for the upper byte
            ifre_pkg::ST_MASK:
            begin
               ccr_i_r    <= 1'b1;
               vec_rd_r   <= 1'b1;
               vec_addr_r <= ifre_pkg::VEC_ADDR_HI;
               st_r       <= ifre_pkg::ST_FHI;
            end
            // Upper byte arrives; ask for the lower one
            ifre_pkg::ST_FHI:
            begin
               pc_hi_r    <= vec_data_in;
               vec_addr_r <= ifre_pkg::VEC_ADDR_LO;
               st_r       <= ifre_pkg::ST_FLO;
            end
            // Lower byte arrives; load and run
            ifre_pkg::ST_FLO:
            begin
               vec_rd_r   <= 1'b0;
               pc_value_r <= {pc_hi_r, vec_data_in};
               pc_load_r  <= 1'b1;
               cpu_run_r  <= 1'b1;
               st_r       <= ifre_pkg::ST_RUN;
            end
            // Stay until the next reset
            ifre_pkg::ST_RUN:
               st_r <= ifre_pkg::ST_RUN;
            default:
               st_r <= ifre_pkg::ST_HOLD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pready_out     = pready_r;
   assign prdata_out     = prdata_r;
   assign pslverr_out    = pslverr_r;
   assign irq_out        = irq_r;
   assign ccr_i_mask_out = ccr_i_r;
   assign vec_rd_out     = vec_rd_r;
   assign vec_addr_out   = vec_addr_r;
   assign pc_load_out    = pc_load_r;
   assign pc_value_out   = pc_value_r;
   assign cpu_run_out    = cpu_run_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   dt_set_a: assert property (dt_hit |=> ptf_r[ifre_pkg::DT_BIT])
      else $error("Direct transition flag not set");
   dt_clear_a: assert property (wr_go && paddr_in == ifre_pkg::ADDR_PTF
      && !pwdata_in[ifre_pkg::DT_BIT] && !dt_hit
      |=> !ptf_r[ifre_pkg::DT_BIT])
      else $error("Direct transition flag not cleared");
   p3_set_a: assert property (pin_hit[1] |=> ptf_r[ifre_pkg::P3_BIT])
      else $error("Pin three flag not set");
   p0_edge_a: assert property (pin_mode[0] && !edge_sel[0]
      && stable[0] && level_r[0] && !sync3_r[0]
      |=> ptf_r[ifre_pkg::P0_BIT])
      else $error("Pin zero falling edge missed");
   p0_hold_a: assert property (ptf_r[ifre_pkg::P0_BIT]
      && !(wr_go && paddr_in == ifre_pkg::ADDR_PTF)
      |=> ptf_r[ifre_pkg::P0_BIT])
      else $error("Pin zero flag lost without write");
   tov_set_a: assert property (timer_ovf_in
      |=> tof_r[ifre_pkg::TOV_BIT])
      else $error("Timer overflow flag not set");
   wake_set_a: assert property (pin_hit[2] |=> wpf_r[ifre_pkg::WK_BIT])
      else $error("Wake pin flag not set");
   keep_one_a: assert property (wr_go && paddr_in == ifre_pkg::ADDR_WPF
      && pwdata_in[ifre_pkg::WK_BIT] && wpf_r[ifre_pkg::WK_BIT]
      |=> wpf_r[ifre_pkg::WK_BIT])
      else $error("Writing one cleared the wake flag");
   fixed_bits_a: assert property (pready_r && !pwrite_in
      && $past(paddr_in) == ifre_pkg::ADDR_PTF
      |-> prdata_r[5:4] == 2'b11 && prdata_r[2:1] == 2'b00)
      else $error("Reserved bits read wrong");
   irq_fwd_a: assert property (irq_out && ena_r == ifre_pkg::ENA_RST
      |-> $past(ena_r) != ifre_pkg::ENA_RST)
      else $error("Request forwarded while disabled");
   entry_seq_a: assert property (st_r == ifre_pkg::ST_MASK
      |-> ##1 ccr_i_mask_out && vec_rd_out ##2 pc_load_out && cpu_run_out)
      else $error("Reset entry sequence timing wrong");

   entry_c: cover property (pc_load_out);
   irq_c: cover property (!irq_out ##1 irq_out);
   clr_c: cover property (ptf_r[ifre_pkg::P3_BIT] ##1
      !ptf_r[ifre_pkg::P3_BIT]);
   err_c: cover property (pslverr_out);

endmodule : ifre_top

// file: verif/ifre_vec_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Vector memory, answers while the address stands
// ----------------------------------------------------------------------
module ifre_vec_mem
#(
   parameter logic [7:0] BYTE_HI = 8'ha5,  // Start address, upper byte
   parameter logic [7:0] BYTE_LO = 8'h3c   // Start address, lower byte
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        rd_in,
   input  wire logic [15:0] addr_in,
   output logic [7:0]       data_out
);
   logic [7:0] last_r;                     // Byte shown last cycle

   // Remember the last byte so an idle bus can show its inverse
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         last_r <= 8'h5a;
      else
         last_r <= data_out;
   end

   // Sequencer samples the byte at the edge that ends the address cycle,
   // so the answer must stand in that same cycle; idle shows the inverse
   always_comb
   begin
      if (rd_in && addr_in == 16'h0000)
         data_out = BYTE_HI;
      else if (rd_in && addr_in == 16'h0001)
         data_out = BYTE_LO;
      else
         data_out = ~last_r;
   end
endmodule : ifre_vec_mem

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk = 1'b0;      // 40 MHz
   logic        rst_n = 1'b0;    // Chip clear, low at start
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, serr;
   logic        sd = 1'b0, dto = 1'b0, tov = 1'b0;
   logic        p3 = 1'b1, p0 = 1'b1, wk = 1'b1; // Pins idle high
   logic        irq, imask, vrd, pcl, run;
   logic [15:0] vaddr, pcv;
   logic [7:0]  vdata;
   int          err_count = 0, n_compared = 0, cyc = 0;

   always #12.5 clk = ~clk;

   ifre_top uut (.ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
      .pslverr_out(pslverr), .sleep_direct_in(sd),
      .direct_transition_on_in(dto), .timer_ovf_in(tov),
      .ext_pin_three_in(p3), .ext_pin_zero_in(p0), .wake_pin_in(wk),
      .irq_out(irq), .ccr_i_mask_out(imask), .vec_rd_out(vrd),
      .vec_addr_out(vaddr), .vec_data_in(vdata), .pc_load_out(pcl),
      .pc_value_out(pcv), .cpu_run_out(run));

   ifre_vec_mem mem (.clk_in(clk), .rst_n_in(rst_n), .rd_in(vrd),
      .addr_in(vaddr), .data_out(vdata));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data taken at the edge with pready high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) err_count++;
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask : rd

   // Reset held three cycles, then the vector walk is followed
   task reset_chip;
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk(imask, 1'b1);
      chk(run, 1'b0);
      chk(vrd, 1'b0);
      rst_n <= 1'b1;
      n = 0;
      while (pcl !== 1'b1 && n < 20) begin @(posedge clk); n++; end
      chk(pcv, 16'ha53c);
      chk(imask, 1'b1);
      chk(run, 1'b1);
      chk(vrd, 1'b0);
   endtask : reset_chip

   // Hang guard, the whole run needs well under 2000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         err_count++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset_chip();
      rd(ifre_pkg::ADDR_PTF, 32'h30);
      rd(ifre_pkg::ADDR_TOF, 32'h1f);
      rd(ifre_pkg::ADDR_WPF, 32'hc0);
      rd(ifre_pkg::ADDR_ENTRY, 32'h5);
      $display("test reset done");
      @(posedge clk) sd <= 1'b1;
      @(posedge clk) sd <= 1'b0;
      rd(ifre_pkg::ADDR_PTF, 32'h30);
      @(posedge clk) begin sd <= 1'b1; dto <= 1'b1; tov <= 1'b1; end
      @(posedge clk) begin sd <= 1'b0; tov <= 1'b0; end
      rd(ifre_pkg::ADDR_PTF, 32'hb0);
      rd(ifre_pkg::ADDR_TOF, 32'h3f);
      apb(1'b1, ifre_pkg::ADDR_PTF, 32'hff);
      apb(1'b1, ifre_pkg::ADDR_TOF, 32'hff);
      rd(ifre_pkg::ADDR_PTF, 32'hb0);
      rd(ifre_pkg::ADDR_TOF, 32'h3f);
      apb(1'b1, ifre_pkg::ADDR_ENA, 32'h02);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b1, ifre_pkg::ADDR_ENA, 32'h80);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b1, ifre_pkg::ADDR_ENA, 32'h29);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      apb(1'b1, ifre_pkg::ADDR_PTF, 32'h0);
      apb(1'b1, ifre_pkg::ADDR_TOF, 32'h0);
      rd(ifre_pkg::ADDR_PTF, 32'h30);
      rd(ifre_pkg::ADDR_TOF, 32'h1f);
      $display("test internal events done");
      // Modes on, pin three rising, others falling; clear mode glitches
      apb(1'b1, ifre_pkg::ADDR_EDGE, 32'h2908);
      apb(1'b1, ifre_pkg::ADDR_PTF, 32'h0);
      apb(1'b1, ifre_pkg::ADDR_WPF, 32'h0);
      p3 <= 1'b0; p0 <= 1'b0;
      repeat (8) @(posedge clk);
      rd(ifre_pkg::ADDR_PTF, 32'h31);
      p3 <= 1'b1;
      repeat (8) @(posedge clk);
      rd(ifre_pkg::ADDR_PTF, 32'h39);
      wk <= 1'b0;
      repeat (8) @(posedge clk);
      rd(ifre_pkg::ADDR_WPF, 32'he0);
      apb(1'b1, ifre_pkg::ADDR_ENA, 32'h01);
      rd(ifre_pkg::ADDR_ENA, 32'h01);
      rd(ifre_pkg::ADDR_EDGE, 32'h2908);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b1, ifre_pkg::ADDR_ENA, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      apb(1'b1, ifre_pkg::ADDR_PTF, 32'h08);
      rd(ifre_pkg::ADDR_PTF, 32'h38);
      apb(1'b1, ifre_pkg::ADDR_WPF, 32'h0);
      rd(ifre_pkg::ADDR_WPF, 32'hc0);
      apb(1'b0, 8'h40, 32'h0);
      chk(serr, 1'b1);
      chk(rdata, 32'h0);
      $display("test pins done");
      // Second reset in mid-run, flags back to their initial values
      reset_chip();
      rd(ifre_pkg::ADDR_PTF, 32'h30);
      rd(ifre_pkg::ADDR_WPF, 32'hc0);
      $display("test second reset done");
      conclude();
   end
endmodule : tb_top
